// [shared/conveyor_pkg.sv]
// Purpose: Shared constants and carriers for the discharge conveyor controller
// Assumes: 125 MHz system clock, APB register access with 32-bit data
// Notes:   Timing figures kept in their own units, cycle counts derived here
package conveyor_pkg;

    // Clock and timing
    localparam int unsigned CLK_HZ       = 125_000_000;
    localparam int unsigned PRESTART_S   = 10;
    localparam int unsigned RUNON_MS     = 2000;
    localparam int unsigned MS_PER_S     = 1000;
    localparam logic [31:0] PRESTART_CYC_DFLT = 32'(PRESTART_S * CLK_HZ);
    localparam logic [31:0] RUNON_CYC_DFLT    = 32'((CLK_HZ / MS_PER_S) * RUNON_MS);

    // APB register map, byte addresses
    localparam int unsigned APB_AW        = 12;
    localparam logic [11:0] REG_CTRL      = 12'h000;
    localparam logic [11:0] REG_STATUS    = 12'h004;

    // CTRL fields
    localparam int unsigned CTRL_ENABLE_BIT = 0;
    localparam logic        CTRL_ENABLE_RST = 1'b1;

    // STATUS fields
    localparam int unsigned ST_STATE_LSB  = 0;
    localparam int unsigned ST_DIR_BIT    = 3;
    localparam int unsigned ST_MODE_LSB   = 4;
    localparam int unsigned ST_CHUTE_BIT  = 6;
    localparam int unsigned ST_GEAR_LSB   = 7;
    localparam int unsigned ST_SPEED_BIT  = 9;
    localparam int unsigned ST_WEIGH_BIT  = 10;
    localparam int unsigned ST_ENABLE_BIT = 11;

    // Mode selector encoding
    typedef enum logic [1:0] {
        MODE_AUTO         = 2'b00,
        MODE_PLANT_MANUAL = 2'b01,
        MODE_LOCAL_MANUAL = 2'b10,
        MODE_INVALID      = 2'b11
    } control_mode_e;

    // Conveyor sequence states
    typedef enum logic [2:0] {
        ST_STOP     = 3'b000,
        ST_FWD_PRE  = 3'b001,
        ST_FWD_RUN  = 3'b010,
        ST_REV_PRE  = 3'b011,
        ST_REV_RUN  = 3'b100,
        ST_CLEAR    = 3'b101
    } conv_state_e;

    typedef struct packed {
        logic [11:0] paddr;
        logic        psel;
        logic        penable;
        logic        pwrite;
        logic [31:0] pwdata;
    } apb_req_s;

    typedef struct packed {
        logic       transfer_running;
        logic       skip_in_pos;
        logic       skip_full;
        logic       weigh_fail;
        logic       chute_blocked;
        logic [1:0] gear_hot;
        logic       speed_fault;
    } plant_in_s;

    typedef struct packed {
        logic fwd_start;
        logic fwd_stop;
        logic rev_start;
        logic rev_stop;
        logic local_start;
        logic local_stop;
        logic estop;
        logic fault_reset;
    } buttons_s;

    typedef struct packed {
        logic forward_prestart_lamp;
        logic forward_running_lamp;
        logic conveyor_stopped_lamp;
        logic reverse_prestart_lamp;
        logic reverse_running_lamp;
        logic belt_clearing_lamp;
        logic skip_present_lamp;
        logic skip_full_lamp;
        logic system_fault_alarm;
    } room_lamps_s;

    typedef struct packed {
        logic       klaxon;
        logic       skip_lamp;
        logic [1:0] gear_hot_lamp;
        logic       chute_lamp;
        logic       weigh_fail_lamp;
        logic       drive_fault_lamp;
    } local_lamps_s;

endpackage

// [rtl/discharge_conveyor_controller.sv]
// Purpose: Sequencer for the two-direction sludge discharge conveyor
// Assumes: Inputs synchronous to i_clk, pushbuttons are levels held while pressed
// Notes:   Registers over APB with zero wait states
//
// Contract
// - Forward normally; reverse when transfer conveyor stops
// - Reverse only with skip present, not full
// - Local emergency stop also stops three filters
// - Apply automatic, plant manual or local manual
// - Automatic: forward after ten-second prestart delay
// - Forward prestart lamp, klaxon; then running lamp
// - Reversal: running lamp off, stopped lamp on
// - Reverse prestart with klaxon, then running lamp
// - Plant manual forward needs transfer conveyor running
// - Plant manual starts wait ten-second prestart
// - Plant manual reverse needs skip present, not full
// - Room lamps show skip present and full
// - Skip full stops reverse at once, any mode
// - Local manual: reverse only, with prestart
// - Chute, gearbox heat, speed fault trip, alarm
// - Normal stop: clearing lamp, short run-on
// - Emergency stop halts conveyor at once
// - Local fault lamps and fault reset input
// - Local pushbuttons act on reverse only
`timescale 1ns/1ns
`default_nettype none

module discharge_conveyor_controller #(
    parameter logic [31:0] PRESTART_CYC = conveyor_pkg::PRESTART_CYC_DFLT,
    parameter logic [31:0] RUNON_CYC    = conveyor_pkg::RUNON_CYC_DFLT
) (
    input  wire logic                        i_clk,
    input  wire logic                        i_rst,
    input  wire conveyor_pkg::apb_req_s      i_apb,
    output logic [31:0]                      o_prdata,
    output logic                             o_pready,
    output logic                             o_pslverr,
    input  wire conveyor_pkg::control_mode_e i_mode,
    input  wire conveyor_pkg::plant_in_s     i_plant,
    input  wire conveyor_pkg::buttons_s      i_btn,
    output logic                             o_motor_fwd,
    output logic                             o_motor_rev,
    output logic [2:0]                       o_filter_stop,
    output conveyor_pkg::room_lamps_s        o_room,
    output conveyor_pkg::local_lamps_s       o_local
);
    import conveyor_pkg::*;

    typedef struct packed {
        conv_state_e  st;
        logic         dir_rev;
        logic [31:0]  cnt;
        logic         enable;
        logic         lat_chute;
        logic [1:0]   lat_gear;
        logic         lat_speed;
        logic [31:0]  prdata;
        logic         motor_fwd;
        logic         motor_rev;
        logic [2:0]   filter_stop;
        room_lamps_s  room;
        local_lamps_s loc;
    } ctl_s;

    localparam ctl_s CTL_RST = '{st: ST_STOP, enable: CTRL_ENABLE_RST, default: '0};

    ctl_s r;
    ctl_s next_r;

    // Address decode for the error answer only; the read mux compares addresses itself
    function automatic logic reg_mapped(input logic [11:0] a);
        return (a == REG_CTRL) || (a == REG_STATUS);
    endfunction

    logic rev_ok;
    logic tripped;
    logic fwd_hold;
    logic rev_hold;
    logic apb_setup;
    logic apb_wr;

    // Sequencer, fault latches, register file and registered outputs
    always_comb begin
        next_r    = r;
        apb_setup = i_apb.psel & ~i_apb.penable;
        apb_wr    = i_apb.psel & i_apb.penable & i_apb.pwrite;
        // Weigh unit failure also blocks reverse: skip state cannot be trusted
        rev_ok = i_plant.skip_in_pos & ~i_plant.skip_full & ~i_plant.weigh_fail;

        // Set wins over reset so a fault present at reset stays latched
        next_r.lat_chute = (r.lat_chute & ~i_btn.fault_reset) | i_plant.chute_blocked;
        next_r.lat_gear  = (r.lat_gear & ~{2{i_btn.fault_reset}}) | i_plant.gear_hot;
        next_r.lat_speed = (r.lat_speed & ~i_btn.fault_reset) | i_plant.speed_fault;
        tripped = next_r.lat_chute | (|next_r.lat_gear) | next_r.lat_speed;

        // Conditions that keep a started direction going, per mode
        fwd_hold = 1'b0;
        rev_hold = 1'b0;
        case (i_mode)
            MODE_AUTO: begin
                fwd_hold = i_plant.transfer_running;
                rev_hold = rev_ok & ~i_plant.transfer_running;
            end
            MODE_PLANT_MANUAL: begin
                fwd_hold = i_plant.transfer_running & ~i_btn.fwd_stop;
                rev_hold = rev_ok & ~i_btn.rev_stop;
            end
            MODE_LOCAL_MANUAL: begin
                fwd_hold = 1'b0;
                rev_hold = rev_ok & ~i_btn.local_stop;
            end
            default: begin
                fwd_hold = 1'b0;
                rev_hold = 1'b0;
            end
        endcase
        fwd_hold = fwd_hold & r.enable;
        rev_hold = rev_hold & r.enable;

        // Direction sequence; every start goes through a prestart state
        case (r.st)
            ST_STOP: begin
                next_r.cnt = '0;
                if (r.enable) begin
                    case (i_mode)
                        MODE_AUTO: begin
                            if (i_plant.transfer_running) begin
                                next_r.st      = ST_FWD_PRE;
                                next_r.dir_rev = 1'b0;
                            end else if (rev_ok) begin
                                next_r.st      = ST_REV_PRE;
                                next_r.dir_rev = 1'b1;
                            end
                        end
                        MODE_PLANT_MANUAL: begin
                            if (i_btn.fwd_start && i_plant.transfer_running) begin
                                next_r.st      = ST_FWD_PRE;
                                next_r.dir_rev = 1'b0;
                            end else if (i_btn.rev_start && rev_ok) begin
                                next_r.st      = ST_REV_PRE;
                                next_r.dir_rev = 1'b1;
                            end
                        end
                        MODE_LOCAL_MANUAL: begin
                            if (i_btn.local_start && rev_ok) begin
                                next_r.st      = ST_REV_PRE;
                                next_r.dir_rev = 1'b1;
                            end
                        end
                        default: begin
                            next_r.st = ST_STOP;
                        end
                    endcase
                end
            end
            ST_FWD_PRE: begin
                if (!fwd_hold) begin
                    next_r.st = ST_STOP;
                end else if (r.cnt == 32'(PRESTART_CYC - 32'h0000_0001)) begin
                    next_r.st  = ST_FWD_RUN;
                    next_r.cnt = '0;
                end else begin
                    next_r.cnt = r.cnt + 32'h0000_0001;
                end
            end
            ST_REV_PRE: begin
                if (!rev_hold) begin
                    next_r.st = ST_STOP;
                end else if (r.cnt == 32'(PRESTART_CYC - 32'h0000_0001)) begin
                    next_r.st  = ST_REV_RUN;
                    next_r.cnt = '0;
                end else begin
                    next_r.cnt = r.cnt + 32'h0000_0001;
                end
            end
            ST_FWD_RUN: begin
                next_r.cnt = '0;
                // No run-on onto a stopped transfer conveyor; reversal starts from stop
                if (!i_plant.transfer_running) begin
                    next_r.st = ST_STOP;
                end else if (!fwd_hold) begin
                    next_r.st = ST_CLEAR;
                end
            end
            ST_REV_RUN: begin
                next_r.cnt = '0;
                if (!rev_ok) begin
                    next_r.st = ST_STOP;
                end else if (!rev_hold) begin
                    next_r.st = ST_CLEAR;
                end
            end
            ST_CLEAR: begin
                if (r.dir_rev && !rev_ok) begin
                    next_r.st  = ST_STOP;
                    next_r.cnt = '0;
                end else if (r.cnt == 32'(RUNON_CYC - 32'h0000_0001)) begin
                    next_r.st  = ST_STOP;
                    next_r.cnt = '0;
                end else begin
                    next_r.cnt = r.cnt + 32'h0000_0001;
                end
            end
            default: begin
                next_r.st  = ST_STOP;
                next_r.cnt = '0;
            end
        endcase

        // Emergency stop and trips skip the run-on entirely
        if (i_btn.estop || tripped) begin
            next_r.st  = ST_STOP;
            next_r.cnt = '0;
        end

        // APB: CTRL write at access phase, read data captured in setup
        if (apb_wr && (i_apb.paddr == REG_CTRL)) begin
            next_r.enable = i_apb.pwdata[CTRL_ENABLE_BIT];
        end
        if (apb_setup) begin
            next_r.prdata = '0;
            if (i_apb.paddr == REG_CTRL) begin
                next_r.prdata[CTRL_ENABLE_BIT] = r.enable;
            end else if (i_apb.paddr == REG_STATUS) begin
                next_r.prdata[ST_STATE_LSB +: 3] = r.st;
                next_r.prdata[ST_DIR_BIT]        = r.dir_rev;
                next_r.prdata[ST_MODE_LSB +: 2]  = i_mode;
                next_r.prdata[ST_CHUTE_BIT]      = r.lat_chute;
                next_r.prdata[ST_GEAR_LSB +: 2]  = r.lat_gear;
                next_r.prdata[ST_SPEED_BIT]      = r.lat_speed;
                next_r.prdata[ST_WEIGH_BIT]      = i_plant.weigh_fail;
                next_r.prdata[ST_ENABLE_BIT]     = r.enable;
            end
        end

        // Outputs decoded from the next state and the plant and button inputs so they leave flip-flops
        next_r.motor_fwd = (next_r.st == ST_FWD_RUN) | ((next_r.st == ST_CLEAR) & ~next_r.dir_rev);
        next_r.motor_rev = (next_r.st == ST_REV_RUN) | ((next_r.st == ST_CLEAR) & next_r.dir_rev);
        next_r.filter_stop = {3{i_btn.estop}};
        next_r.room.forward_prestart_lamp = (next_r.st == ST_FWD_PRE);
        next_r.room.forward_running_lamp  = (next_r.st == ST_FWD_RUN);
        next_r.room.reverse_prestart_lamp = (next_r.st == ST_REV_PRE);
        next_r.room.reverse_running_lamp  = (next_r.st == ST_REV_RUN);
        next_r.room.conveyor_stopped_lamp = ~next_r.motor_fwd & ~next_r.motor_rev;
        next_r.room.belt_clearing_lamp    = (next_r.st == ST_CLEAR);
        next_r.room.skip_present_lamp     = i_plant.skip_in_pos;
        next_r.room.skip_full_lamp        = i_plant.skip_full;
        next_r.room.system_fault_alarm    = tripped;
        next_r.loc.klaxon           = (next_r.st == ST_FWD_PRE) | (next_r.st == ST_REV_PRE);
        next_r.loc.skip_lamp        = i_plant.skip_in_pos;
        next_r.loc.gear_hot_lamp    = next_r.lat_gear;
        next_r.loc.chute_lamp       = next_r.lat_chute;
        next_r.loc.weigh_fail_lamp  = i_plant.weigh_fail;
        next_r.loc.drive_fault_lamp = next_r.lat_speed;
    end

    // Single state register, synchronous reset
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            r <= CTL_RST;
        end else begin
            r <= next_r;
        end
    end

    // Zero wait state slave; unmapped addresses answer with an error
    assign o_pready      = 1'b1;
    assign o_pslverr     = i_apb.psel & i_apb.penable & ~reg_mapped(i_apb.paddr);
    assign o_prdata      = r.prdata;
    assign o_motor_fwd   = r.motor_fwd;
    assign o_motor_rev   = r.motor_rev;
    assign o_filter_stop = r.filter_stop;
    assign o_room        = r.room;
    assign o_local       = r.loc;

    // Length of the prestart lamp period, for checking only
    logic [31:0] ast_pre_cnt;
    always_ff @(posedge i_clk) begin
        if (i_rst) begin
            ast_pre_cnt <= '0;
        end else if (o_room.forward_prestart_lamp || o_room.reverse_prestart_lamp) begin
            ast_pre_cnt <= ast_pre_cnt + 32'h0000_0001;
        end else begin
            ast_pre_cnt <= '0;
        end
    end

    AST_MOTOR_EXCLUSIVE: assert property (@(posedge i_clk) disable iff (i_rst)
        !(o_motor_fwd && o_motor_rev))
        else $error("both motor outputs asserted");

    AST_DIR_VIA_STOP: assert property (@(posedge i_clk) disable iff (i_rst)
        $fell(o_motor_fwd) |-> !o_motor_rev ##1 !o_motor_rev)
        else $error("reverse followed forward without a stop");

    AST_ESTOP_HALT: assert property (@(posedge i_clk) disable iff (i_rst)
        i_btn.estop |=> !o_motor_fwd && !o_motor_rev && !o_room.belt_clearing_lamp)
        else $error("emergency stop did not halt conveyor");

    AST_ESTOP_FILTERS: assert property (@(posedge i_clk) disable iff (i_rst)
        i_btn.estop |=> (o_filter_stop == 3'h7))
        else $error("emergency stop did not stop all filters");

    AST_SKIP_FULL_STOP: assert property (@(posedge i_clk) disable iff (i_rst)
        i_plant.skip_full |=> !o_motor_rev)
        else $error("reverse kept running with skip full");

    AST_REV_PERMIT: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(o_motor_rev) |-> $past(i_plant.skip_in_pos) && !$past(i_plant.skip_full))
        else $error("reverse started without a ready skip");

    AST_PRESTART_LEN: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(o_motor_fwd) || $rose(o_motor_rev) |-> ast_pre_cnt == PRESTART_CYC)
        else $error("motor started without full prestart delay");

    AST_FWD_LAMPS: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(o_motor_fwd) |-> $past(o_room.forward_prestart_lamp) && !o_room.forward_prestart_lamp
            && o_room.forward_running_lamp)
        else $error("forward lamp sequence wrong");

    AST_KLAXON: assert property (@(posedge i_clk) disable iff (i_rst)
        (o_room.forward_prestart_lamp || o_room.reverse_prestart_lamp) |-> o_local.klaxon)
        else $error("klaxon silent during prestart");

    AST_PLANT_FWD_REFUSE: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(o_room.forward_prestart_lamp) && $past(i_mode) == MODE_PLANT_MANUAL
            |-> $past(i_plant.transfer_running) && $past(i_btn.fwd_start))
        else $error("plant manual forward start not refused");

    AST_LOCAL_NO_FWD: assert property (@(posedge i_clk) disable iff (i_rst)
        $past(i_mode) == MODE_LOCAL_MANUAL |-> !$rose(o_room.forward_prestart_lamp))
        else $error("forward start in local manual mode");

    AST_TRIP: assert property (@(posedge i_clk) disable iff (i_rst)
        (i_plant.chute_blocked || i_plant.speed_fault || (|i_plant.gear_hot))
            |=> !o_motor_fwd && !o_motor_rev && o_room.system_fault_alarm)
        else $error("fault did not trip conveyor");

    AST_RUNON: assert property (@(posedge i_clk) disable iff (i_rst)
        $rose(o_room.belt_clearing_lamp) |-> (o_motor_fwd || o_motor_rev))
        else $error("clearing run-on without motor");

endmodule

`default_nettype wire

// [tb/conveyor_plant_model.sv]
// Purpose: Plant side stand-in: transfer conveyor, skip on weigh bridge, sensors
// Assumes: Bench commands plant levels; skip fills while the reverse belt runs
// Notes:   Fill level is registered, so full shows one edge after the last load
`timescale 1ns/1ns
`default_nettype none
module conveyor_plant_model
#(
    parameter int FILL_CYC = 10
) (
    input  wire logic                    i_clk,
    input  wire logic                    i_rst,
    input  wire logic                    i_motor_rev,
    input  wire logic                    i_empty,
    input  wire conveyor_pkg::plant_in_s i_cmd,
    output conveyor_pkg::plant_in_s      o_plant
);
    import conveyor_pkg::*;
    int fill;
    // Skip loads with every reverse cycle, emptied on bench command
    always_ff @(posedge i_clk) begin
        if (i_rst || i_empty) begin
            fill <= 0;
        end else if (i_motor_rev) begin
            fill <= fill + 1;
        end
    end
    // Full comes from the load, or is forced by the bench
    always_comb begin
        o_plant = i_cmd;
        o_plant.skip_full = i_cmd.skip_full || (fill >= FILL_CYC);
    end
endmodule
`default_nettype wire

// [tb/discharge_conveyor_controller_test.sv]
// Purpose: Self-checking bench for the discharge conveyor controller
// Assumes: Short prestart and run-on counts; plant model beside the device
// Notes:   Random APB addresses come from a small LFSR seeded at 38
`timescale 1ns/1ns
`default_nettype none
module discharge_conveyor_controller_test;
    import conveyor_pkg::*;
    localparam logic [31:0] PRE  = 32'h0000_0008;
    localparam logic [31:0] RUN  = 32'h0000_0005;
    localparam int          FILL = 10;
    logic          i_clk     = 1'b0;
    logic          i_rst     = 1'b1;
    apb_req_s      apb_r     = '0;
    control_mode_e mode      = MODE_INVALID;
    plant_in_s     cmd       = '0;
    buttons_s      btn       = '0;
    logic          empty     = 1'b0;
    logic [15:0]   seed      = 16'h0026;
    int            error_cnt = 0;
    int            compares  = 0;
    logic [31:0]   prdata;
    logic          pready;
    logic          pslverr;
    plant_in_s     plant;
    logic          motor_fwd;
    logic          motor_rev;
    logic [2:0]    filter_stop;
    room_lamps_s   room;
    local_lamps_s  loc;
    logic [31:0]   rd;
    logic          er;
    int            n;

    // Free-running system clock
    always #4 i_clk = ~i_clk;

    discharge_conveyor_controller #(.PRESTART_CYC(PRE), .RUNON_CYC(RUN)) dut (
        .i_clk(i_clk), .i_rst(i_rst), .i_apb(apb_r), .o_prdata(prdata), .o_pready(pready),
        .o_pslverr(pslverr), .i_mode(mode), .i_plant(plant), .i_btn(btn), .o_motor_fwd(motor_fwd),
        .o_motor_rev(motor_rev), .o_filter_stop(filter_stop), .o_room(room), .o_local(loc));

    conveyor_plant_model #(.FILL_CYC(FILL)) plant_side (
        .i_clk(i_clk), .i_rst(i_rst), .i_motor_rev(motor_rev), .i_empty(empty),
        .i_cmd(cmd), .o_plant(plant));

    function automatic logic [15:0] lfsr(input logic [15:0] s);
        return {s[14:0], s[15] ^ s[13] ^ s[12] ^ s[10]};
    endfunction

    // Lamp under measurement: 0 fwd prestart, 1 rev prestart, 2 clearing
    function automatic logic pick(input int w);
        return (w == 0) ? room.forward_prestart_lamp :
               (w == 1) ? room.reverse_prestart_lamp : room.belt_clearing_lamp;
    endfunction

    task automatic finish_test;
        $display("compares %0d errors %0d", compares, error_cnt);
        if (error_cnt == 0 && compares > 0) begin
            $display("ALL TESTS PASSED");
        end else begin
            $display("TESTS FAILED");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] got, input logic [31:0] exp, input string m);
        compares++;
        if (got !== exp) begin
            error_cnt++;
            $display("[ERR] %0t %s got %0h exp %0h", $time, m, got, exp);
        end
    endtask

    task automatic timeout;
        error_cnt++;
        $display("[ERR] %0t wait ran out", $time);
        finish_test();
    endtask

    task automatic cyc(input int k);
        repeat (k) @(posedge i_clk);
        #1;
    endtask

    // Hold button for one edge, release on the next
    task automatic press(input int b);
        @(posedge i_clk);
        btn[b] <= 1'b1;
        @(posedge i_clk);
        btn[b] <= 1'b0;
    endtask

    // Count cycles a lamp stays lit; returns in the first dark cycle
    task automatic span(input int w, output int c);
        int k;
        c = 0;
        for (k = 0; k < 200; k++) begin
            #1;
            if (pick(w) === 1'b1) begin
                c++;
                if (w < 2) chk(loc.klaxon, 1, "klaxon silent in prestart");
            end else if (c > 0) begin
                break;
            end
            @(posedge i_clk);
        end
        if (k == 200) timeout();
    endtask

    // Request held from setup until pready is seen at an edge
    task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] d,
                       output logic [31:0] r, output logic e);
        int k;
        @(posedge i_clk);
        apb_r <= '{paddr: a, psel: 1'b1, penable: 1'b0, pwrite: w, pwdata: d};
        @(posedge i_clk);
        apb_r.penable <= 1'b1;
        for (k = 0; k < 50; k++) begin
            @(posedge i_clk);
            if (pready === 1'b1) break;
        end
        if (k == 50) timeout();
        r = prdata;
        e = pslverr;
        apb_r.psel <= 1'b0;
        apb_r.penable <= 1'b0;
    endtask

    // Both starters at once would short the drives
    always @(posedge i_clk) begin
        if (!i_rst && motor_fwd === 1'b1 && motor_rev === 1'b1) begin
            chk(0, 1, "both motors on");
        end
    end

    initial begin
        cmd.skip_in_pos = 1'b1;
        repeat (6) @(posedge i_clk);
        i_rst <= 1'b0;
        // Register reset values, random reads, enable write
        apb(1'b0, REG_CTRL, 32'h0000_0000, rd, er);
        chk(rd[0], CTRL_ENABLE_RST, "ctrl reset");
        apb(1'b0, REG_STATUS, 32'h0000_0000, rd, er);
        chk({rd[11], rd[2:0]}, 4'h8, "status reset");
        for (int i = 0; i < 6; i++) begin
            seed = lfsr(seed);
            apb(1'b0, {seed[11:2], 2'b00}, 32'h0000_0000, rd, er);
            chk(er, ({seed[11:2], 2'b00} > 12'h004), "pslverr");
        end
        apb(1'b1, REG_CTRL, {seed, seed[15:1], 1'b0}, rd, er);
        apb(1'b0, REG_CTRL, 32'h0000_0000, rd, er);
        chk(rd[0], 0, "enable clear");
        for (int m = 0; m < 4; m++) begin
            @(posedge i_clk);
            mode <= control_mode_e'(m);
            apb(1'b0, REG_STATUS, 32'h0000_0000, rd, er);
            chk(rd[5:4], m, "mode field");
        end
        @(posedge i_clk);
        cmd.transfer_running <= 1'b1;
        apb(1'b1, REG_CTRL, 32'h0000_0001, rd, er);
        cyc(12);
        chk(room.forward_prestart_lamp, 0, "start in invalid mode");
        $display("test registers done");
        // Automatic forward, reversal, full skip
        @(posedge i_clk);
        mode <= MODE_AUTO;
        span(0, n);
        chk(n, PRE, "fwd prestart length");
        chk({motor_fwd, room.forward_running_lamp}, 2'h3, "fwd start");
        @(posedge i_clk);
        cmd.transfer_running <= 1'b0;
        cyc(1);
        chk({motor_fwd, room.forward_running_lamp, room.conveyor_stopped_lamp}, 3'h1, "reversal stop");
        span(1, n);
        chk(n, PRE, "rev prestart length");
        chk({motor_rev, room.reverse_running_lamp}, 2'h3, "rev start");
        n = 1;
        while (motor_rev === 1'b1 && n < 100) begin
            cyc(1);
            n++;
        end
        chk(n, FILL + 2, "rev stop on full");
        chk({room.skip_present_lamp, room.skip_full_lamp}, 2'h3, "skip lamps");
        cyc(12);
        chk(room.reverse_prestart_lamp, 0, "rev with full skip");
        $display("test auto done");
        // Emptied skip restarts reverse; transfer back gives run-on
        press(0);
        empty <= 1'b1;
        @(posedge i_clk);
        empty <= 1'b0;
        span(1, n);
        chk(n, PRE, "rev restart");
        @(posedge i_clk);
        cmd.transfer_running <= 1'b1;
        span(2, n);
        chk(n, RUN, "run-on length");
        chk(motor_rev, 0, "after run-on");
        span(0, n);
        chk(n, PRE, "fwd after stop");
        @(posedge i_clk);
        btn.estop <= 1'b1;
        cyc(1);
        chk({motor_fwd, room.belt_clearing_lamp, filter_stop}, 5'h07, "emergency stop");
        @(posedge i_clk);
        btn.estop <= 1'b0;
        $display("test estop done");
        // Plant manual: buttons, interlocks, normal stops
        @(posedge i_clk);
        mode <= MODE_PLANT_MANUAL;
        cmd.transfer_running <= 1'b0;
        empty <= 1'b1;
        repeat (30) @(posedge i_clk);
        empty <= 1'b0;
        press(7);
        cyc(12);
        chk({motor_fwd, room.forward_prestart_lamp}, 0, "fwd without transfer");
        press(5);
        span(1, n);
        chk(n, PRE, "plant rev prestart");
        press(4);
        span(2, n);
        chk(n, RUN, "plant rev run-on");
        @(posedge i_clk);
        cmd.transfer_running <= 1'b1;
        press(7);
        span(0, n);
        chk(n, PRE, "plant fwd prestart");
        press(6);
        span(2, n);
        chk(n, RUN, "plant fwd run-on");
        $display("test plant manual done");
        // Local manual: reverse only, then a trip and reset
        @(posedge i_clk);
        mode <= MODE_LOCAL_MANUAL;
        press(7);
        cyc(12);
        chk(room.forward_prestart_lamp, 0, "fwd in local");
        press(3);
        span(1, n);
        chk(n, PRE, "local rev prestart");
        @(posedge i_clk);
        cmd.chute_blocked <= 1'b1;
        cyc(1);
        chk({motor_rev, room.system_fault_alarm, loc.chute_lamp, loc.skip_lamp}, 4'h7, "chute trip");
        @(posedge i_clk);
        cmd.chute_blocked <= 1'b0;
        press(0);
        cyc(2);
        chk({room.system_fault_alarm, loc.chute_lamp}, 0, "fault reset");
        @(posedge i_clk);
        cmd <= '{skip_in_pos: 1'b1, weigh_fail: 1'b1, gear_hot: 2'h2, speed_fault: 1'b1, default: '0};
        cyc(1);
        chk({room.system_fault_alarm, loc.gear_hot_lamp, loc.weigh_fail_lamp, loc.drive_fault_lamp}, 5'h1b, "drive faults");
        $display("test local manual done");
        finish_test();
    end
endmodule
`default_nettype wire
